// ### core/isf_pkg.sv
`default_nettype none

package isf_pkg;

    // Register map of the port: one register at each of indices 0 to 5; indices 6 and 7 are unmapped.
    localparam int REG_ADDR_W = 3;
    localparam logic [2:0] OFS_STATUS = 3'h0;
    localparam logic [2:0] OFS_CTRL = 3'h1;
    localparam logic [2:0] OFS_SLAVE_ADDR = 3'h2;
    localparam logic [2:0] OFS_DATA = 3'h3;
    localparam logic [2:0] OFS_EVENT = 3'h4;
    localparam logic [2:0] OFS_MASK = 3'h5;

    // Bit positions of bus_status.
    localparam int TC_BIT = 7;
    localparam int AAS_BIT = 6;
    localparam int BUSY_BIT = 5;
    localparam int ARB_BIT = 4;
    localparam int UNUSED_BIT = 3;
    localparam int DIR_BIT = 2;
    localparam int PEND_BIT = 1;
    localparam int ACK_BIT = 0;

    // Bit positions of the control register.
    localparam int CTRL_TX_BIT = 0;
    localparam int CTRL_GCE_BIT = 1;

    // Bit positions of the event and mask registers.
    localparam int EVT_W = 4;
    localparam int EVT_BYTE = 0;
    localparam int EVT_ADDR = 1;
    localparam int EVT_ARB = 2;
    localparam int EVT_STOP = 3;

    // Reset values.
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [6:0] SLAVE_ADDR_RST = 7'h00;
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam logic [7:0] DATA_RST = 8'h00;

    // Bus constants.
    localparam logic [6:0] GENERAL_CALL = 7'h00;
    localparam int BIT_CNT_W = 4;
    localparam logic [3:0] ACK_SLOT = 4'h8;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } isf_reg_req_type;

    typedef struct packed {
        logic startSeen;
        logic stopSeen;
        logic sclRise;
        logic sdaLevel;
        logic byteStart;
        logic byteDone;
        logic addrByte;
        logic ackLevel;
        logic [7:0] rxByte;
    } isf_bus_evt_type;

endpackage : isf_pkg

`default_nettype wire

// ### core/isf_bus_monitor.sv
`default_nettype none

module isf_bus_monitor (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sclPin,
    input wire logic sdaPin,
    output isf_pkg::isf_bus_evt_type busEvt
);

    logic [1:0] sclSync;
    logic [1:0] sdaSync;
    logic sclPrev;
    logic sdaPrev;
    logic sclRise;
    logic startDet;
    logic stopDet;
    logic inFrame;
    logic firstByte;
    logic [isf_pkg::BIT_CNT_W-1:0] bitCnt;
    logic [7:0] shiftReg;

    // Two flip-flops on each pin; only the second stage is read.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sclSync <= 2'h3;
            sdaSync <= 2'h3;
        end else begin
            sclSync <= {sclSync[0], sclPin};
            sdaSync <= {sdaSync[0], sdaPin};
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclPrev <= sclSync[1];
            sdaPrev <= sdaSync[1];
        end
    end

    assign sclRise = sclSync[1] && !sclPrev;
    assign startDet = sclSync[1] && sclPrev && sdaPrev && !sdaSync[1];
    assign stopDet = sclSync[1] && sclPrev && !sdaPrev && sdaSync[1];

    // Bit counter: eight data bits then the acknowledge slot.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            inFrame <= 1'b0;
            firstByte <= 1'b0;
            bitCnt <= '0;
            shiftReg <= 8'h00;
        end else if (startDet) begin
            inFrame <= 1'b1;
            firstByte <= 1'b1;
            bitCnt <= '0;
        end else if (stopDet) begin
            inFrame <= 1'b0;
            bitCnt <= '0;
        end else if (sclRise && inFrame) begin
            if (bitCnt == isf_pkg::ACK_SLOT) begin
                bitCnt <= '0;
                firstByte <= 1'b0;
            end else begin
                bitCnt <= bitCnt + 4'h1;
                shiftReg <= {shiftReg[6:0], sdaSync[1]};
            end
        end
    end

    // Registered event record handed to the flag logic.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busEvt <= '0;
        end else begin
            busEvt.startSeen <= startDet;
            busEvt.stopSeen <= stopDet;
            busEvt.sclRise <= sclRise;
            busEvt.sdaLevel <= sdaSync[1];
            busEvt.byteStart <= sclRise && inFrame && !startDet
                && bitCnt == '0;
            busEvt.byteDone <= sclRise && inFrame && !startDet
                && bitCnt == isf_pkg::ACK_SLOT;
            busEvt.addrByte <= firstByte;
            busEvt.ackLevel <= sdaSync[1];
            busEvt.rxByte <= shiftReg;
        end
    end

endmodule : isf_bus_monitor

`default_nettype wire

// ### core/isf_status_flags.sv
// Function
// - Byte completion sets transfer complete, bit 7.
// - Data read in receive, write in transmit clear it.
// - Transfer complete meaningful only around a transfer.
// - Address match or general call sets bit 6.
// - Control register write clears addressed flag.
// - Start sets busy bit 5, stop clears.
// - Arbitration loss sets bit 4.
// - Writing one to bit 4 clears arbitration lost.
// - Bit 2 holds calling read/write direction.
// - Byte, match or arbitration loss sets bit 1.
// - Writing one clears interrupt pending.
// - Bit 0 holds sampled acknowledge after byte.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`default_nettype none

module isf_status_flags #(
    parameter int REG_ADDR_W = isf_pkg::REG_ADDR_W
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sclPin,
    input wire logic sdaPin,
    input wire logic masterActive,
    input wire logic masterSdaOut,
    input wire isf_pkg::isf_reg_req_type regReq,
    output logic [7:0] rdData,
    output logic irq
);

    if (REG_ADDR_W != isf_pkg::REG_ADDR_W) begin : gen_bad_width
        $error("Register index width must match the register map.");
    end

    isf_pkg::isf_bus_evt_type busEvt;

    logic transferCompleteFlag;
    logic addressedAsSlaveFlag;
    logic busBusyFlag;
    logic arbitrationLostFlag;
    logic slaveDirectionFlag;
    logic interruptPendingFlag;
    logic receivedAckFlag;
    logic [7:0] ctrl_reg;
    logic [6:0] slaveAddr_reg;
    logic [7:0] txData_reg;
    logic [7:0] rxData_reg;
    logic [isf_pkg::EVT_W-1:0] event_reg;
    logic [isf_pkg::EVT_W-1:0] event_next;
    logic [isf_pkg::EVT_W-1:0] mask_reg;
    logic [7:0] statusValue;
    logic txMode;
    logic generalCallEnable;
    logic addrMatch;
    logic involved;
    logic tcSet;
    logic arbLoss;
    logic statusWr;
    logic ctrlWr;
    logic dataWr;
    logic dataRd;

    function automatic logic regWrite(input isf_pkg::isf_reg_req_type req,
                                      input logic [2:0] ofs);
        regWrite = req.wr && req.addr == ofs;
    endfunction : regWrite

    function automatic logic regRead(input isf_pkg::isf_reg_req_type req,
                                     input logic [2:0] ofs);
        regRead = req.rd && req.addr == ofs;
    endfunction : regRead

    isf_bus_monitor u_monitor (
        .mclk(mclk),
        .rst_n(rst_n),
        .sclPin(sclPin),
        .sdaPin(sdaPin),
        .busEvt(busEvt)
    );

    assign txMode = ctrl_reg[isf_pkg::CTRL_TX_BIT];
    assign generalCallEnable = ctrl_reg[isf_pkg::CTRL_GCE_BIT];
    assign statusWr = regWrite(regReq, isf_pkg::OFS_STATUS);
    assign ctrlWr = regWrite(regReq, isf_pkg::OFS_CTRL);
    assign dataWr = regWrite(regReq, isf_pkg::OFS_DATA);
    assign dataRd = regRead(regReq, isf_pkg::OFS_DATA);

    // Address phase compare, including general call when enabled.
    assign addrMatch = busEvt.byteDone && busEvt.addrByte
        && (busEvt.rxByte[7:1] == slaveAddr_reg
        || (generalCallEnable
        && busEvt.rxByte[7:1] == isf_pkg::GENERAL_CALL));
    assign involved = masterActive || addressedAsSlaveFlag || addrMatch;
    assign tcSet = busEvt.byteDone && involved;
    // Released high by our master while another party pulls low.
    assign arbLoss = masterActive && masterSdaOut && busEvt.sclRise
        && !busEvt.sdaLevel;

    // Transfer complete: cleared when the next byte begins.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            transferCompleteFlag <= 1'b0;
        end else if (tcSet) begin
            transferCompleteFlag <= 1'b1;
        end else if (busEvt.byteStart
                     || (dataRd && !txMode) || (dataWr && txMode)) begin
            transferCompleteFlag <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            addressedAsSlaveFlag <= 1'b0;
        end else if (addrMatch) begin
            addressedAsSlaveFlag <= 1'b1;
        end else if (ctrlWr) begin
            addressedAsSlaveFlag <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            slaveDirectionFlag <= 1'b0;
        end else if (addrMatch) begin
            slaveDirectionFlag <= busEvt.rxByte[0];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busBusyFlag <= 1'b0;
        end else if (busEvt.startSeen) begin
            busBusyFlag <= 1'b1;
        end else if (busEvt.stopSeen) begin
            busBusyFlag <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            arbitrationLostFlag <= 1'b0;
        end else if (arbLoss) begin
            arbitrationLostFlag <= 1'b1;
        end else if (statusWr && regReq.wdata[isf_pkg::ARB_BIT]) begin
            arbitrationLostFlag <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            interruptPendingFlag <= 1'b0;
        end else if (tcSet || addrMatch || arbLoss) begin
            interruptPendingFlag <= 1'b1;
        end else if (statusWr && regReq.wdata[isf_pkg::PEND_BIT]) begin
            interruptPendingFlag <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            receivedAckFlag <= 1'b0;
        end else if (tcSet) begin
            receivedAckFlag <= busEvt.ackLevel;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= isf_pkg::CTRL_RST;
            slaveAddr_reg <= isf_pkg::SLAVE_ADDR_RST;
            txData_reg <= isf_pkg::DATA_RST;
            mask_reg <= isf_pkg::MASK_RST;
        end else if (regReq.wr) begin
            case (regReq.addr)
                isf_pkg::OFS_CTRL: ctrl_reg <= regReq.wdata;
                isf_pkg::OFS_SLAVE_ADDR: slaveAddr_reg <= regReq.wdata[7:1];
                isf_pkg::OFS_DATA: txData_reg <= regReq.wdata;
                isf_pkg::OFS_MASK: mask_reg <= regReq.wdata[3:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rxData_reg <= isf_pkg::DATA_RST;
        end else if (tcSet) begin
            rxData_reg <= busEvt.rxByte;
        end
    end

    // Sticky events: a new event wins over a clearing write.
    always_comb begin
        event_next = event_reg;
        if (regWrite(regReq, isf_pkg::OFS_EVENT)) begin
            event_next = event_reg & ~regReq.wdata[3:0];
        end
        event_next[isf_pkg::EVT_BYTE] = event_next[isf_pkg::EVT_BYTE] | tcSet;
        event_next[isf_pkg::EVT_ADDR] = event_next[isf_pkg::EVT_ADDR]
            | addrMatch;
        event_next[isf_pkg::EVT_ARB] = event_next[isf_pkg::EVT_ARB] | arbLoss;
        event_next[isf_pkg::EVT_STOP] = event_next[isf_pkg::EVT_STOP]
            | busEvt.stopSeen;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            event_reg <= '0;
        end else begin
            event_reg <= event_next;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(event_reg & mask_reg);
        end
    end

    // Bus status image; the unused bit is tied low.
    always_comb begin
        statusValue = 8'h00;
        statusValue[isf_pkg::TC_BIT] = transferCompleteFlag;
        statusValue[isf_pkg::AAS_BIT] = addressedAsSlaveFlag;
        statusValue[isf_pkg::BUSY_BIT] = busBusyFlag;
        statusValue[isf_pkg::ARB_BIT] = arbitrationLostFlag;
        statusValue[isf_pkg::DIR_BIT] = slaveDirectionFlag;
        statusValue[isf_pkg::PEND_BIT] = interruptPendingFlag;
        statusValue[isf_pkg::ACK_BIT] = receivedAckFlag;
    end

    // Read data stand in the cycle after the strobe; unmapped reads zero.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdData <= 8'h00;
        end else if (regReq.rd) begin
            case (regReq.addr)
                isf_pkg::OFS_STATUS: rdData <= statusValue;
                isf_pkg::OFS_CTRL: rdData <= ctrl_reg;
                isf_pkg::OFS_SLAVE_ADDR: rdData <= {slaveAddr_reg, 1'b0};
                isf_pkg::OFS_DATA: rdData <= txMode ? txData_reg : rxData_reg;
                isf_pkg::OFS_EVENT: rdData <= {4'h0, event_reg};
                isf_pkg::OFS_MASK: rdData <= {4'h0, mask_reg};
                default: rdData <= 8'h00;
            endcase
        end else begin
            rdData <= 8'h00;
        end
    end

    chk_tc_set: assert property (@(posedge mclk) disable iff (!rst_n)
        tcSet |=> transferCompleteFlag ##1 (transferCompleteFlag
        || $past(busEvt.byteStart) || $past(dataRd) || $past(dataWr)))
        else $error("Transfer complete not held after byte.");

    chk_tc_clear: assert property (@(posedge mclk)
        disable iff (!rst_n)
        ((dataRd && !txMode) || (dataWr && txMode)) && !tcSet
        |=> !transferCompleteFlag)
        else $error("Transfer complete not cleared by data access.");

    chk_slave_match: assert property (@(posedge mclk)
        disable iff (!rst_n)
        addrMatch |=> addressedAsSlaveFlag
        && slaveDirectionFlag == $past(busEvt.rxByte[0]))
        else $error("Address match not recorded.");

    chk_ctrl_clear: assert property (@(posedge mclk)
        disable iff (!rst_n)
        ctrlWr && !addrMatch |=> !addressedAsSlaveFlag)
        else $error("Control write left addressed flag set.");

    chk_busy_track: assert property (@(posedge mclk)
        disable iff (!rst_n)
        busEvt.startSeen ##1 !busEvt.stopSeen[*2] |-> busBusyFlag)
        else $error("Busy flag not set after start.");

    chk_busy_clear: assert property (@(posedge mclk)
        disable iff (!rst_n)
        busEvt.stopSeen && !busEvt.startSeen |=> !busBusyFlag)
        else $error("Busy flag not cleared after stop.");

    chk_arb_sticky: assert property (@(posedge mclk)
        disable iff (!rst_n)
        arbitrationLostFlag && !(statusWr && regReq.wdata[isf_pkg::ARB_BIT])
        |=> arbitrationLostFlag)
        else $error("Arbitration lost flag cleared on its own.");

    chk_arb_set: assert property (@(posedge mclk)
        disable iff (!rst_n)
        arbLoss |=> arbitrationLostFlag && interruptPendingFlag)
        else $error("Arbitration loss not flagged.");

    chk_pend_clear: assert property (@(posedge mclk)
        disable iff (!rst_n)
        statusWr && regReq.wdata[isf_pkg::PEND_BIT]
        && !(tcSet || addrMatch || arbLoss) |=> !interruptPendingFlag)
        else $error("Interrupt pending not cleared by write of one.");

    chk_ack_capture: assert property (@(posedge mclk)
        disable iff (!rst_n)
        tcSet |=> receivedAckFlag == $past(busEvt.ackLevel))
        else $error("Acknowledge level not captured.");

    chk_unused_zero: assert property (@(posedge mclk)
        disable iff (!rst_n)
        regRead(regReq, isf_pkg::OFS_STATUS) |=> !rdData[isf_pkg::UNUSED_BIT]
        && rdData == $past(statusValue))
        else $error("Status read returned wrong value.");

    chk_zero_write: assert property (@(posedge mclk)
        disable iff (!rst_n)
        statusWr && regReq.wdata == 8'h00 && !arbLoss && !busEvt.startSeen
        && !busEvt.stopSeen && !tcSet && !addrMatch && !busEvt.byteStart
        |=> $stable(statusValue))
        else $error("Zero write changed the status flags.");

    chk_irq_level: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 irq == |($past(event_reg) & $past(mask_reg)))
        else $error("Interrupt output disagrees with events.");

endmodule : isf_status_flags

`default_nettype wire

// ### sim/isf_bus_model.sv
`default_nettype none

module isf_bus_model (
    output logic scl,
    output logic sda
);
    timeunit 1ns;
    timeprecision 100ps;

    // Both lines rest high; the clock stands still between frames.
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    task automatic startCond;
        sda = 1'b1;
        scl = 1'b1;
        #100;
        sda = 1'b0;
        #100;
        scl = 1'b0;
    endtask : startCond

    task automatic stopCond;
        #20;
        sda = 1'b0;
        #80;
        scl = 1'b1;
        #100;
        sda = 1'b1;
        #100;
    endtask : stopCond

    task automatic sendBit(input logic b);
        #20;
        sda = b;
        #80;
        scl = 1'b1;
        #100;
        scl = 1'b0;
    endtask : sendBit

    // Eight bits, most significant first, then the acknowledge slot.
    task automatic sendByte(input logic [7:0] data, input logic ack);
        for (int i = 7; i >= 0; i--) begin
            sendBit(data[i]);
        end
        sendBit(ack);
        #20;
        sda = 1'b1;
    endtask : sendByte

endmodule : isf_bus_model

`default_nettype wire

// ### sim/isf_status_flags_tb.sv
`default_nettype none

module isf_status_flags_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic mclk;
    logic rst_n;
    logic sclPin;
    logic sdaPin;
    logic masterActive;
    logic masterSdaOut;
    isf_pkg::isf_reg_req_type regReq;
    logic [7:0] rdData;
    logic irq;
    int errorCnt;
    int checksDone;

    isf_status_flags dut (
        .mclk(mclk),
        .rst_n(rst_n),
        .sclPin(sclPin),
        .sdaPin(sdaPin),
        .masterActive(masterActive),
        .masterSdaOut(masterSdaOut),
        .regReq(regReq),
        .rdData(rdData),
        .irq(irq)
    );

    isf_bus_model bus (
        .scl(sclPin),
        .sda(sdaPin)
    );

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errorCnt++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    task automatic regWrite(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        regReq.wr <= 1'b0;
    endtask : regWrite

    task automatic regRead(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk);
        regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        regReq.rd <= 1'b0;
        #1;
        d = rdData;
    endtask : regRead

    task automatic settle;
        repeat (12) @(posedge mclk);
    endtask : settle

    task automatic readStatus(output logic [7:0] d);
        regRead(isf_pkg::OFS_STATUS, d);
    endtask : readStatus

    task automatic testReset;
        logic [7:0] v;
        check("irq at reset", {7'h00, irq}, 8'h00);
        readStatus(v);
        check("status at reset", v, 8'h00);
        regWrite(isf_pkg::OFS_STATUS, 8'h08);
        readStatus(v);
        check("unused bit", v, 8'h00);
        regWrite(3'h7, 8'hff);
        regRead(3'h7, v);
        check("unmapped read", v, 8'h00);
    endtask : testReset

    task automatic testSlave;
        logic [7:0] v;
        regWrite(isf_pkg::OFS_SLAVE_ADDR, 8'ha4);
        regWrite(isf_pkg::OFS_CTRL, 8'h00);
        bus.startCond();
        settle();
        readStatus(v);
        check("busy on start", v, 8'h20);
        bus.sendByte(8'ha4, 1'b0);
        settle();
        readStatus(v);
        check("address match", v, 8'he2);
        regRead(isf_pkg::OFS_DATA, v);
        check("received byte", v, 8'ha4);
        readStatus(v);
        check("receive data read", v, 8'h62);
        regWrite(isf_pkg::OFS_STATUS, 8'h02);
        readStatus(v);
        check("pending clear", v, 8'h60);
        bus.sendByte(8'h3c, 1'b1);
        settle();
        readStatus(v);
        check("byte without ack", v, 8'he3);
        regWrite(isf_pkg::OFS_CTRL, 8'h01);
        readStatus(v);
        check("control write", v, 8'ha3);
        regWrite(isf_pkg::OFS_DATA, 8'h55);
        readStatus(v);
        check("transmit data write", v, 8'h23);
        regRead(isf_pkg::OFS_DATA, v);
        check("transmit data", v, 8'h55);
        regWrite(isf_pkg::OFS_STATUS, 8'h00);
        readStatus(v);
        check("zero write", v, 8'h23);
        regWrite(isf_pkg::OFS_STATUS, 8'hff);
        readStatus(v);
        check("ones write", v, 8'h21);
        bus.stopCond();
        settle();
        readStatus(v);
        check("idle on stop", v, 8'h01);
    endtask : testSlave

    task automatic testGeneralCall;
        logic [7:0] v;
        for (int en = 0; en < 2; en++) begin
            regWrite(isf_pkg::OFS_CTRL, {6'h00, en[0], 1'b0});
            bus.startCond();
            bus.sendByte(8'h00, 1'b0);
            settle();
            readStatus(v);
            check("general call", v & 8'h40, {1'b0, en[0], 6'h00});
            bus.stopCond();
        end
        regWrite(isf_pkg::OFS_CTRL, 8'h00);
        bus.startCond();
        bus.sendByte(8'ha5, 1'b0);
        settle();
        readStatus(v);
        check("slave transmit", v & 8'h44, 8'h44);
        bus.stopCond();
    endtask : testGeneralCall

    task automatic testArbitration;
        logic [7:0] v;
        regWrite(isf_pkg::OFS_STATUS, 8'hff);
        @(posedge mclk);
        masterActive <= 1'b1;
        masterSdaOut <= 1'b0;
        bus.startCond();
        bus.sendByte(8'h00, 1'b1);
        bus.stopCond();
        settle();
        readStatus(v);
        check("no loss when driving", v & 8'h10, 8'h00);
        @(posedge mclk);
        masterActive <= 1'b1;
        masterSdaOut <= 1'b1;
        bus.startCond();
        bus.sendByte(8'h00, 1'b1);
        @(posedge mclk);
        masterActive <= 1'b0;
        bus.stopCond();
        settle();
        readStatus(v);
        check("arbitration lost", v & 8'h12, 8'h12);
        regRead(isf_pkg::OFS_EVENT, v);
        check("arbitration event", v & 8'h04, 8'h04);
        regWrite(isf_pkg::OFS_STATUS, 8'h10);
        readStatus(v);
        check("arbitration clear", v & 8'h12, 8'h02);
        regWrite(isf_pkg::OFS_STATUS, 8'h02);
    endtask : testArbitration

    task automatic testIrq;
        logic [7:0] v;
        for (int m = 0; m < 2; m++) begin
            regWrite(isf_pkg::OFS_EVENT, 8'hff);
            regWrite(isf_pkg::OFS_MASK, {4'h0, m[0], 3'h0});
            bus.startCond();
            bus.stopCond();
            settle();
            regRead(isf_pkg::OFS_EVENT, v);
            check("stop event", v & 8'h08, 8'h08);
            check("irq on stop", {7'h00, irq}, {7'h00, m[0]});
            regWrite(isf_pkg::OFS_EVENT, 8'h08);
            settle();
            check("irq cleared", {7'h00, irq}, 8'h00);
        end
    endtask : testIrq

    task automatic giveVerdict;
        $display("checks %0d errors %0d", checksDone, errorCnt);
        if (errorCnt == 0 && checksDone > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : giveVerdict

    initial begin
        #1000000;
        errorCnt++;
        giveVerdict();
    end

    initial begin
        errorCnt = 0;
        checksDone = 0;
        rst_n = 1'b0;
        masterActive = 1'b0;
        masterSdaOut = 1'b1;
        regReq = '{addr: 3'h0, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        testReset();
        testSlave();
        testGeneralCall();
        testArbitration();
        testIrq();
        giveVerdict();
    end

endmodule : isf_status_flags_tb

`default_nettype wire
